/* File: design/deac_map.vh */
// What this block does
// - read byte lands in data low next cycle
// - data low holds until next read or write
// - core reads ignore data protect bit
// - write needs 55h, AAh, then write strobe
// - write strobe blocked while write permit clear
// - write permit changed only by software, reset
// - clearing write permit does not abort write
// - write end clears strobe, sets done flag
// - reset clears write permit
// - power-up timer blocks write start
// - protected data denies external access
// - program read: two cycles, word to data
// - done flag raises irq with enables
`ifndef DEAC_MAP_VH
`define DEAC_MAP_VH
`define DEAC_UNLOCK_FIRST 8'h55
`define DEAC_UNLOCK_SECOND 8'hAA
`define DEAC_CLK_NS 10
`define DEAC_PWRUP_MS 64
`define DEAC_PWRUP_CYCLES ((`DEAC_PWRUP_MS * 1000000) / `DEAC_CLK_NS)
`define DEAC_WRITE_CYCLES 400000
`define DEAC_PROG_READ_CYCLES 2
`define DEAC_DATA_RESET 8'h00
`endif

/* File: design/deac_unlock.v */
`timescale 1ns/1ns
`include "deac_map.vh"
module deac_unlock (
  input wire clock,
  input wire rst,
  input wire unlock_we,
  input wire [7:0] unlock_data,
  input wire ctrl_we,
  input wire consume,
  output reg armed_q
);
  reg first_q;
  always @(posedge clock) begin
    if (rst) begin
      first_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (unlock_we) begin
      // any other unlock value breaks the sequence
      first_q <= (unlock_data == `DEAC_UNLOCK_FIRST);
      armed_q <= first_q && (unlock_data == `DEAC_UNLOCK_SECOND);
    end else if (ctrl_we || consume) begin
      // the strobe must come with the next control write; one arming per byte
      first_q <= 1'b0;
      armed_q <= 1'b0;
    end
  end
endmodule

/* File: design/deac_ctrl.v */
`timescale 1ns/1ns
`include "deac_map.vh"
module deac_ctrl #(
  parameter AW = 15,
  parameter PWRUP_CYCLES = `DEAC_PWRUP_CYCLES,
  parameter WRITE_CYCLES = `DEAC_WRITE_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire addr_low_we,
  input wire addr_high_we,
  input wire data_low_we,
  input wire data_high_we,
  input wire [7:0] wdata,
  input wire unlock_we,
  input wire ctrl_we,
  input wire program_space_select_in,
  input wire config_space_select_in,
  input wire write_permit_in,
  input wire write_strobe_in,
  input wire read_strobe_in,
  input wire done_flag_we,
  input wire done_flag_in,
  input wire write_done_irq_enable,
  input wire global_irq_enable,
  input wire peripheral_irq_enable,
  input wire data_protect_n,
  input wire ext_access_req,
  input wire [7:0] ee_rdata,
  input wire [13:0] prog_rdata,
  output reg [7:0] nv_address_low_q,
  output reg [AW-9:0] nv_address_high_q,
  output reg [7:0] nv_data_low_q,
  output reg [7:0] nv_data_high_q,
  output reg program_space_select_q,
  output reg config_space_select_q,
  output reg write_permit_q,
  output reg write_strobe_q,
  output reg write_done_flag_q,
  output reg irq_q,
  output reg ee_write_q,
  output reg ext_access_grant_q,
  output reg prog_busy_q
);
  localparam ST_IDLE = 3'b001;
  localparam ST_PROG = 3'b010;
  localparam ST_WRITE = 3'b100;
  localparam [31:0] PWR_W = PWRUP_CYCLES;
  localparam [31:0] WR_W = WRITE_CYCLES;
  localparam [31:0] PROG_W = `DEAC_PROG_READ_CYCLES;

  // shared counter step; the power-up counter stops at its limit and the write counter clears, so no wrap is reached
  function [31:0] count_next;
    input [31:0] count;
    begin
      count_next = count + 32'h00000001;
    end
  endfunction

  // true on the cycle whose step brings the count to its limit
  function reached;
    input [31:0] count;
    input [31:0] limit;
    begin
      reached = (count_next(count) >= limit);
    end
  endfunction

  reg [2:0] state_q;
  reg [31:0] pwr_cnt_q;
  reg [31:0] wr_cnt_q;
  reg [1:0] prog_cnt_q;
  reg pwr_done_q;
  wire armed;
  wire consume;
  wire busy;
  wire data_space;
  wire start_write;
  wire start_read;
  wire prog_read;
  wire data_read;
  wire write_last;
  wire prog_last;
  reg [2:0] state_d;
  reg prot_meta_q;
  reg prot_sync_q;
  reg req_meta_q;
  reg req_sync_q;

  assign busy = (state_q != ST_IDLE);
  assign data_space = !program_space_select_q && !config_space_select_q;
  // strobe taken only when armed, permitted, timer elapsed and idle
  assign start_write = ctrl_we && write_strobe_in && write_permit_in && armed
    && pwr_done_q && !busy;
  assign start_read = ctrl_we && read_strobe_in && !busy;
  assign consume = start_write;
  assign prog_read = start_read && program_space_select_in && !start_write;
  // config-space reads are accepted but do nothing
  assign data_read = start_read && !program_space_select_in && !config_space_select_in
    && !start_write;
  assign write_last = (state_q == ST_WRITE) && reached(wr_cnt_q, WR_W);
  assign prog_last = (state_q == ST_PROG)
    && ({{30{1'b0}}, prog_cnt_q} == (PROG_W - 32'h00000001));

  deac_unlock u_unlock (
    .clock(clock),
    .rst(rst),
    .unlock_we(unlock_we && !busy),
    .unlock_data(wdata),
    .ctrl_we(ctrl_we),
    .consume(consume),
    .armed_q(armed)
  );

  // power-up timer counts after reset release
  always @(posedge clock) begin
    if (rst) begin
      pwr_cnt_q <= 32'h00000000;
      pwr_done_q <= 1'b0;
    end else if (!pwr_done_q) begin
      pwr_cnt_q <= count_next(pwr_cnt_q);
      pwr_done_q <= reached(pwr_cnt_q, PWR_W);
    end
  end

  // address registers
  always @(posedge clock) begin
    if (rst) begin
      nv_address_low_q <= 8'h00;
      nv_address_high_q <= {(AW-8){1'b0}};
    end else begin
      if (addr_low_we) begin
        nv_address_low_q <= wdata;
      end
      if (addr_high_we) begin
        nv_address_high_q <= wdata[AW-9:0];
      end
    end
  end

  // control bits; write permit only from software or reset
  always @(posedge clock) begin
    if (rst) begin
      program_space_select_q <= 1'b0;
      config_space_select_q <= 1'b0;
      write_permit_q <= 1'b0;
    end else if (ctrl_we) begin
      program_space_select_q <= program_space_select_in;
      config_space_select_q <= config_space_select_in;
      write_permit_q <= write_permit_in;
    end
  end

  // next-state decode; a write request wins over a read in the same control write
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (start_write) begin
          state_d = ST_WRITE;
        end else if (prog_read) begin
          state_d = ST_PROG;
        end
      end
      ST_PROG: begin
        if (prog_last) begin
          state_d = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (write_last) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // self-timed write; write permit no longer looked at
  always @(posedge clock) begin
    if (rst) begin
      wr_cnt_q <= 32'h00000000;
    end else if (state_q == ST_WRITE) begin
      wr_cnt_q <= count_next(wr_cnt_q);
    end else begin
      wr_cnt_q <= 32'h00000000;
    end
  end

  // counts the cycles of a program read until its last cycle
  always @(posedge clock) begin
    if (rst) begin
      prog_cnt_q <= 2'b00;
    end else if (state_q == ST_PROG) begin
      prog_cnt_q <= prog_cnt_q + 2'b01;
    end else begin
      prog_cnt_q <= 2'b00;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      write_strobe_q <= 1'b0;
    end else if (start_write) begin
      write_strobe_q <= 1'b1;
    end else if (write_last) begin
      write_strobe_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      prog_busy_q <= 1'b0;
    end else if (prog_read) begin
      prog_busy_q <= 1'b1;
    end else if (prog_last) begin
      prog_busy_q <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      ee_write_q <= 1'b0;
    end else begin
      ee_write_q <= write_last;
    end
  end

  // a read result overrides a software write in the same cycle
  always @(posedge clock) begin
    if (rst) begin
      nv_data_low_q <= `DEAC_DATA_RESET;
    end else if (prog_last) begin
      nv_data_low_q <= prog_rdata[7:0];
    end else if (data_read) begin
      nv_data_low_q <= ee_rdata;
    end else if (data_low_we) begin
      nv_data_low_q <= wdata;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      nv_data_high_q <= `DEAC_DATA_RESET;
    end else if (prog_last) begin
      nv_data_high_q <= {2'b00, prog_rdata[13:8]};
    end else if (data_high_we) begin
      nv_data_high_q <= wdata;
    end
  end

  // done flag: hardware set beats software clear
  always @(posedge clock) begin
    if (rst) begin
      write_done_flag_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (write_last) begin
        write_done_flag_q <= 1'b1;
      end else if (done_flag_we) begin
        write_done_flag_q <= done_flag_in;
      end
      irq_q <= write_done_flag_q && write_done_irq_enable && global_irq_enable
        && peripheral_irq_enable;
    end
  end

  // protect level crosses in through two flops; resets to protected for safety
  always @(posedge clock) begin
    if (rst) begin
      prot_meta_q <= 1'b0;
      prot_sync_q <= 1'b0;
    end else begin
      prot_meta_q <= data_protect_n;
      prot_sync_q <= prot_meta_q;
    end
  end

  // external request comes from another domain
  always @(posedge clock) begin
    if (rst) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= ext_access_req;
      req_sync_q <= req_meta_q;
    end
  end

  // external access only when data is unprotected
  always @(posedge clock) begin
    if (rst) begin
      ext_access_grant_q <= 1'b0;
    end else begin
      ext_access_grant_q <= req_sync_q && prot_sync_q;
    end
  end
endmodule

/* File: tb/deac_assertions.sv */
`timescale 1ns/1ns
module deac_assertions #(
  parameter PWRUP_CYCLES = 20,
  parameter WRITE_CYCLES = 8
) (
  input logic clock,
  input logic rst,
  input logic ctrl_we,
  input logic read_strobe_in,
  input logic program_space_select_in,
  input logic config_space_select_in,
  input logic write_strobe_in,
  input logic write_permit_in,
  input logic data_low_we,
  input logic done_flag_we,
  input logic [7:0] ee_rdata,
  input logic [7:0] nv_data_low_q,
  input logic write_strobe_q,
  input logic write_permit_q,
  input logic write_done_flag_q,
  input logic irq_q,
  input logic write_done_irq_enable,
  input logic global_irq_enable,
  input logic peripheral_irq_enable,
  input logic ee_write_q,
  input logic ext_access_grant_q,
  input logic data_protect_n,
  input logic prog_busy_q
);
  logic [31:0] busy_q, up_q;
  logic start_q, en_q;
  logic [1:0] plow_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // counters let long spans be checked without huge repetitions
  always @(posedge clock) begin
    busy_q <= (rst || !write_strobe_q) ? 32'h0 : busy_q + 32'h1;
    up_q <= rst ? 32'h0 : up_q + {31'h0, up_q < PWRUP_CYCLES};
    start_q <= ctrl_we & write_strobe_in & write_permit_in;
    plow_q <= (rst || data_protect_n) ? 2'h0 : plow_q + {1'b0, plow_q != 2'h3};
    en_q <= write_done_flag_q & write_done_irq_enable & global_irq_enable & peripheral_irq_enable;
  end
  a_read_next: assert property (
    ctrl_we && read_strobe_in && !program_space_select_in && !config_space_select_in
    && !write_strobe_q && !prog_busy_q && !data_low_we |=> nv_data_low_q == $past(ee_rdata))
    else $error("read byte not loaded");
  a_busy_hold: assert property (write_strobe_q && !data_low_we |=> $stable(nv_data_low_q))
    else $error("data changed during write");
  a_start_cause: assert property ($rose(write_strobe_q) |-> start_q)
    else $error("write started without request");
  a_write_len: assert property ($fell(write_strobe_q) |-> busy_q == WRITE_CYCLES)
    else $error("write length wrong");
  a_done_set: assert property ($fell(write_strobe_q) |-> write_done_flag_q && ee_write_q)
    else $error("write end without flag");
  a_flag_sticky: assert property (write_done_flag_q && !done_flag_we |=> write_done_flag_q)
    else $error("flag dropped");
  a_irq_follow: assert property (irq_q == en_q)
    else $error("irq mismatch");
  a_permit_soft: assert property (!ctrl_we |=> $stable(write_permit_q))
    else $error("permit changed by hardware");
  a_pwrup_block: assert property (up_q < PWRUP_CYCLES |-> !write_strobe_q)
    else $error("write during power-up");
  a_protect_deny: assert property (plow_q == 2'h3 |-> !ext_access_grant_q)
    else $error("external access granted");
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic clock = 0, rst = 1, alw = 0, dlw = 0, uw = 0, cw = 0, wp = 0, ws = 0, rs = 0;
  logic fw = 0, ie = 1, dpn = 1, rv = 0, sv = 0, ps = 0, cs = 0;
  logic [7:0] wd = 8'h00, wa, wv;
  logic [7:0] m [0:255];
  logic [15:0] e, g, q [$];
  logic [31:0] lf = 32'h000125E2;
  int mismatches = 0, samples_checked = 0;
  wire [7:0] al, dl;
  wire [6:0] ah;
  wire perm, stb, flg, irq, eew, grant;
  wire [15:0] st = {11'h000, perm, stb, flg, irq, grant};
  deac_ctrl #(.PWRUP_CYCLES(20), .WRITE_CYCLES(8)) dut_u (
    .clock(clock), .rst(rst), .addr_low_we(alw), .addr_high_we(1'b0), .data_low_we(dlw),
    .data_high_we(1'b0), .wdata(wd), .unlock_we(uw), .ctrl_we(cw),
    .program_space_select_in(ps), .config_space_select_in(cs), .write_permit_in(wp),
    .write_strobe_in(ws), .read_strobe_in(rs), .done_flag_we(fw), .done_flag_in(1'b0),
    .write_done_irq_enable(ie), .global_irq_enable(ie), .peripheral_irq_enable(ie),
    .data_protect_n(dpn), .ext_access_req(ie), .ee_rdata(m[al]), .prog_rdata({ah[5:0], al}),
    .nv_address_low_q(al), .nv_address_high_q(ah), .nv_data_low_q(dl), .nv_data_high_q(),
    .program_space_select_q(), .config_space_select_q(), .write_permit_q(perm),
    .write_strobe_q(stb), .write_done_flag_q(flg), .irq_q(irq), .ee_write_q(eew),
    .ext_access_grant_q(grant), .prog_busy_q());
  function logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task cy(int n); repeat (n) @(negedge clock); endtask
  task unl(logic [7:0] v); wd = v; uw = 1; cy(1); uw = 0; endtask
  task ld(logic [7:0] a, logic [7:0] d); wd = a; alw = 1; cy(1); alw = 0; wd = d; dlw = 1; cy(1); dlw = 0; endtask
  task ctl(logic p, logic s, logic r); wp = p; ws = s; rs = r; cw = 1; cy(1); cw = 0; ws = 0; rs = 0; endtask
  task ex(logic [15:0] v, logic s); q.push_back(v); sv <= s; rv <= !s; cy(1); sv <= 0; rv <= 0; endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial forever #5 clock = ~clock;
  always @(posedge clock) if (eew) m[al] <= dl;
  // sampled at the rising edge so outputs seen are those of the settled cycle
  always @(posedge clock) if (eew || rv || sv) begin
    e = q.pop_front();
    g = sv ? st : {al, dl};
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", sv ? "status" : "data", e, g);
    end
  end
  initial begin
    #10000;
    mismatches++;
    test_done;
  end
  initial begin
    foreach (m[k]) m[k] = 8'h00;
    cy(16);
    rst = 0;
    ex(16'h0000, 1);
    unl(8'h55);
    unl(8'hAA);
    ctl(1, 1, 0);
    cy(9);
    ex(16'h0011, 1);
    cy(10);
    for (int i = 0; i < 5; i++) begin
      lf = nx(lf);
      ld(lf[7:0], lf[15:8]);
      if (i < 4) unl(i == 1 ? 8'hAA : 8'h55);
      if (i < 4) unl(i == 1 || i == 2 ? 8'h55 : 8'hAA);
      if (i == 0) q.push_back({lf[7:0], lf[15:8]});
      ctl(i != 3, 1, 0);
      if (i == 0) ctl(0, 0, 0);
      cy(12);
      ex(i == 0 ? 16'h0007 : i == 3 ? 16'h0001 : 16'h0011, 1);
      if (i == 0) begin
        wa = lf[7:0];
        wv = lf[15:8];
        fw = 1;
        cy(1);
        fw = 0;
      end
      $display("write case %0d done", i);
    end
    dpn = 0;
    ld(wa, ~wv);
    ctl(0, 0, 1);
    ex({wa, wv}, 0);
    cy(4);
    ex({wa, wv}, 0);
    ex(16'h0000, 1);
    $display("read case done");
    cs = 1;
    ctl(0, 0, 1);
    cs = 0;
    ex({wa, wv}, 0);
    ps = 1;
    ctl(0, 0, 1);
    ps = 0;
    cy(3);
    ex({wa, wa}, 0);
    $display("program read case done");
    test_done;
  end
endmodule
bind deac_ctrl deac_assertions #(.PWRUP_CYCLES(PWRUP_CYCLES), .WRITE_CYCLES(WRITE_CYCLES)) chk_u (.*);
